// ===== src/hwpe_pkg.sv
package hwpe_pkg;
   localparam logic [7:0] ADDR_MODE      = 8'h01;
   localparam logic [7:0] ADDR_RTAMP     = 8'h02;
   localparam logic [7:0] ADDR_SEQ_FIRST = 8'h04;
   localparam logic [7:0] ADDR_SEQ_LAST  = 8'h0b;
   localparam logic [7:0] ADDR_GO        = 8'h0c;
   localparam logic [7:0] ADDR_LOOPCFG   = 8'h1c;
   localparam logic [7:0] ADDR_INCTRL    = 8'h1d;
   localparam logic [7:0] ADDR_RAM_HI    = 8'hfd;
   localparam logic [7:0] ADDR_RAM_LO    = 8'hfe;
   localparam logic [7:0] ADDR_RAM_DATA  = 8'hff;

   localparam logic [7:0] RST_MODE    = 8'h40;
   localparam logic [7:0] RST_SEQ1    = 8'h01;
   localparam logic [7:0] RST_SEQ     = 8'h00;
   localparam logic [7:0] RST_LOOPCFG = 8'hf5;
   localparam logic [7:0] RST_INCTRL  = 8'h80;

   localparam int BIT_STANDBY    = 6;
   localparam int BIT_SIGNED_SEL = 7;
   localparam int BIT_OPEN_LOOP  = 5;
   localparam int BIT_RT_FORMAT  = 3;
   localparam int BIT_ANALOG_SEL = 1;
   localparam int BIT_MARK       = 7;

   localparam logic [2:0] MODE_INTERNAL = 3'h0;
   localparam logic [2:0] MODE_EDGE     = 3'h1;
   localparam logic [2:0] MODE_LEVEL    = 3'h2;
   localparam logic [2:0] MODE_INPUT    = 3'h3;
   localparam logic [2:0] MODE_REALTIME = 3'h5;
   localparam logic [2:0] REP_FOREVER   = 3'h7;
   localparam logic [4:0] SIZE_MAX      = 5'h1e;
   localparam logic [7:0] MID_SCALE     = 8'h80;

   localparam int RAM_BYTES = 2048;
   localparam int RAM_AW    = 11;
   localparam logic [10:0] HDR_BASE = 11'h001;
   localparam logic [10:0] HDR_STEP = 11'h003;
   localparam int PWM_WIN_W = 8;
   localparam int CNT_W     = 18;

   localparam int CLK_HZ   = 25000000;
   localparam int TICK_MS  = 5;
   localparam int PAUSE_MS = 10;
   localparam int TICK_CYC  = CLK_HZ / 1000 * TICK_MS;
   localparam int PAUSE_CYC = CLK_HZ / 1000 * PAUSE_MS;

   typedef enum logic [3:0] {
      E_IDLE, E_SLOT, E_PAUSE, E_HDR_HI, E_HDR_LO, E_HDR_CFG,
      E_VOLT, E_TIME, E_VOLT_NEXT, E_HOLD, E_END_EFFECT
   } hwpe_eng_state_t;

   typedef struct packed {
      logic       we;
      logic [7:0] addr;
      logic [7:0] wdata;
   } hwpe_link_req_t;
endpackage

// ===== src/hwpe_playback_engine.sv
`timescale 1ns/1ns
module hwpe_playback_engine #(
   parameter int TICK_CYCLES  = hwpe_pkg::TICK_CYC,
   parameter int PAUSE_CYCLES = hwpe_pkg::PAUSE_CYC
) (
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   input  wire logic       clkEn,
   input  wire logic       linkClk,
   input  wire logic       linkRst,
   input  wire logic       linkReq,
   input  wire logic       linkWe,
   input  wire logic [7:0] linkAddr,
   input  wire logic [7:0] linkWdata,
   output logic            linkReady,
   output logic [7:0]      linkRdata,
   output logic            linkDone,
   input  wire logic       inputTriggerPin,
   input  wire logic [7:0] analogLevel,
   output logic [7:0]      driveLevel,
   output logic            driveActive
);
   typedef struct packed {
      hwpe_pkg::hwpe_eng_state_t eng;
      logic [7:0][7:0] seq;
      logic [17:0]     cycCnt;
      logic [10:0]     ramPtr, memAddr, pairAddr, effStart;
      logic [8:0]      pwmHigh;
      logic [7:0]      modeReg, rtAmp, loopCfg, inCtrl, rdData, pwmWin, pwmDuty, drive;
      logic [7:0]      v1, v2, ticks, elapsed;
      logic [4:0]      effSize, bytesLeft;
      logic [2:0]      reqSync, pinSync, slot, repCfg, repLeft;
      logic            go, ackTgl, pinLvl, ramp, active;
   } hwpe_sys_state_t;

   typedef struct packed {
      hwpe_pkg::hwpe_link_req_t held;
      logic [2:0]               ackSync;
      logic [7:0]               rdata;
      logic                     reqTgl, ready, done;
   } hwpe_link_state_t;

   localparam hwpe_sys_state_t SYS_RESET = '{
      eng:     hwpe_pkg::E_IDLE,
      modeReg: hwpe_pkg::RST_MODE,
      seq:     {{7{hwpe_pkg::RST_SEQ}}, hwpe_pkg::RST_SEQ1},
      loopCfg: hwpe_pkg::RST_LOOPCFG,
      inCtrl:  hwpe_pkg::RST_INCTRL,
      default: '0
   };
   localparam hwpe_link_state_t LINK_RESET = '{ready: 1'b1, default: '0};
   localparam logic [17:0] TICK_LAST  = 18'(TICK_CYCLES - 1);
   localparam logic [17:0] PAUSE_LAST = 18'(PAUSE_CYCLES - 1);
   localparam logic [17:0] TICK_TAIL  = 18'(TICK_CYCLES - 3);

   hwpe_sys_state_t  s;
   hwpe_sys_state_t  d;
   hwpe_link_state_t l;
   hwpe_link_state_t ld;

   // Library store with separate host and engine read addresses; both reads are asynchronous
   logic [7:0]  waveRam [hwpe_pkg::RAM_BYTES];
   logic        ramWe, acc, nextSlot, finish, seqMode, pinRise, act;
   logic [7:0]  ramEngData, ramHostData, slotVal, lvl, accAddr;
   logic [2:0]  modeSel;

   assign ramEngData  = waveRam[s.memAddr];
   assign ramHostData = waveRam[s.ramPtr];

   always_ff @(posedge clk_sys)
   begin
      if (clkEn && ramWe)
      begin
         waveRam[s.ramPtr] <= l.held.wdata;
      end
   end

   function automatic logic [7:0] voltToLevel(input logic [7:0] v, input logic signedSel);
      return signedSel ? {~v[6], v[5:0], 1'b0} : {v[6:0], 1'b0};
   endfunction

   function automatic logic [7:0] rampLevel(input logic [7:0] a, input logic [7:0] b,
                                            input logic [7:0] e, input logic [7:0] t);
      logic signed [8:0]  diff;
      logic signed [17:0] prod;
      logic signed [17:0] q;
      logic signed [9:0]  sum;
      diff = $signed({1'b0, b}) - $signed({1'b0, a});
      prod = diff * $signed({1'b0, e});
      q    = (t == 8'h00) ? 18'sh00000 : prod / $signed({10'h000, t});
      sum  = $signed({2'b00, a}) + $signed(q[9:0]);
      return sum[7:0];
   endfunction

   always_comb
   begin
      d        = s;
      ramWe    = 1'b0;
      nextSlot = 1'b0;
      finish   = 1'b0;
      lvl      = s.drive;
      act      = s.active;
      modeSel  = s.modeReg[2:0];
      accAddr  = l.held.addr;
      seqMode  = (modeSel <= hwpe_pkg::MODE_LEVEL) && !s.modeReg[hwpe_pkg::BIT_STANDBY];
      slotVal  = s.seq[s.slot];

      // Pin: a change counts once second and third stages agree
      d.pinSync = {s.pinSync[1:0], inputTriggerPin};
      pinRise   = 1'b0;
      if (s.pinSync[1] == s.pinSync[2])
      begin
         d.pinLvl = s.pinSync[2];
         pinRise  = s.pinSync[2] && !s.pinLvl;
      end

      // Duty measured over a fixed window; jitter if period does not divide it
      d.pwmWin = s.pwmWin + 8'h01;
      d.pwmHigh = s.pwmHigh + {8'h00, s.pinLvl};
      if (s.pwmWin == '1)
      begin
         d.pwmDuty = s.pwmHigh[8] ? 8'hff : s.pwmHigh[7:0];
         d.pwmHigh = 9'h000;
      end

      case (s.eng)
         hwpe_pkg::E_IDLE:
         begin
            if (s.go && seqMode)
            begin
               d.slot = 3'h0;
               d.eng  = hwpe_pkg::E_SLOT;
            end
         end
         hwpe_pkg::E_SLOT:
         begin
            if (slotVal == 8'h00)
               finish = 1'b1;
            else if (slotVal[hwpe_pkg::BIT_MARK])
            begin
               d.ticks   = {1'b0, slotVal[6:0]};
               d.elapsed = 8'h00;
               d.cycCnt  = '0;
               d.eng     = hwpe_pkg::E_PAUSE;
            end
            else
            begin
               d.memAddr = hwpe_pkg::HDR_BASE
                         + 11'(({4'h0, slotVal[6:0]} - 11'h001) * hwpe_pkg::HDR_STEP);
               d.eng     = hwpe_pkg::E_HDR_HI;
            end
         end
         hwpe_pkg::E_PAUSE:
         begin
            if (s.elapsed == s.ticks)
               nextSlot = 1'b1;
            else if (s.cycCnt == PAUSE_LAST)
            begin
               d.cycCnt  = '0;
               d.elapsed = s.elapsed + 8'h01;
            end
            else
               d.cycCnt = s.cycCnt + 18'h00001;
         end
         hwpe_pkg::E_HDR_HI:
         begin
            d.effStart[10:8] = ramEngData[2:0];
            d.memAddr        = s.memAddr + 11'h001;
            d.eng            = hwpe_pkg::E_HDR_LO;
         end
         hwpe_pkg::E_HDR_LO:
         begin
            d.effStart[7:0] = ramEngData;
            d.memAddr       = s.memAddr + 11'h001;
            d.eng           = hwpe_pkg::E_HDR_CFG;
         end
         hwpe_pkg::E_HDR_CFG:
         begin
            // Broken size entries skip the effect rather than run off the table
            if (ramEngData[4:0] == 5'h00 || ramEngData[0] || ramEngData[4:0] > hwpe_pkg::SIZE_MAX)
               nextSlot = 1'b1;
            else
            begin
               d.effSize   = ramEngData[4:0];
               d.bytesLeft = ramEngData[4:0];
               d.repCfg    = ramEngData[7:5];
               d.repLeft   = ramEngData[7:5];
               d.memAddr   = s.effStart;
               d.pairAddr  = s.effStart;
               d.eng       = hwpe_pkg::E_VOLT;
            end
         end
         hwpe_pkg::E_VOLT:
         begin
            d.v1      = ramEngData;
            d.memAddr = s.memAddr + 11'h001;
            d.eng     = hwpe_pkg::E_TIME;
         end
         hwpe_pkg::E_TIME:
         begin
            d.ticks   = ramEngData;
            d.elapsed = 8'h00;
            d.cycCnt  = '0;
            d.ramp    = s.v1[hwpe_pkg::BIT_MARK] && (s.bytesLeft >= 5'h04);
            d.memAddr = s.memAddr + 11'h001;
            d.eng     = (s.v1[hwpe_pkg::BIT_MARK] && (s.bytesLeft >= 5'h04))
                      ? hwpe_pkg::E_VOLT_NEXT : hwpe_pkg::E_HOLD;
         end
         hwpe_pkg::E_VOLT_NEXT:
         begin
            d.v2  = ramEngData;
            d.eng = hwpe_pkg::E_HOLD;
         end
         hwpe_pkg::E_HOLD:
         begin
            // Last tick yields two cycles to the next pair's fetch; needs three or more
            if (s.ticks == 8'h00 || (s.elapsed == s.ticks - 8'h01 && s.cycCnt == TICK_TAIL))
            begin
               // Next pair starts at the end voltage, whose mark is read afresh
               d.bytesLeft = s.bytesLeft - 5'h02;
               d.pairAddr  = s.pairAddr + 11'h002;
               d.memAddr   = s.pairAddr + 11'h002;
               d.eng       = (s.bytesLeft == 5'h02) ? hwpe_pkg::E_END_EFFECT : hwpe_pkg::E_VOLT;
            end
            else if (s.cycCnt == TICK_LAST)
            begin
               d.cycCnt  = '0;
               d.elapsed = s.elapsed + 8'h01;
            end
            else
               d.cycCnt = s.cycCnt + 18'h00001;
         end
         hwpe_pkg::E_END_EFFECT:
         begin
            if (s.repCfg == hwpe_pkg::REP_FOREVER || s.repLeft != 3'h0)
            begin
               if (s.repCfg != hwpe_pkg::REP_FOREVER)
                  d.repLeft = s.repLeft - 3'h1;
               d.bytesLeft = s.effSize;
               d.memAddr   = s.effStart;
               d.pairAddr  = s.effStart;
               d.eng       = hwpe_pkg::E_VOLT;
            end
            else
               nextSlot = 1'b1;
         end
         default:
            d.eng = hwpe_pkg::E_IDLE;
      endcase

      if (nextSlot)
      begin
         if (s.slot == 3'h7)
            finish = 1'b1;
         else
         begin
            d.slot = s.slot + 3'h1;
            d.eng  = hwpe_pkg::E_SLOT;
         end
      end
      if (finish)
      begin
         d.go  = 1'b0;
         d.eng = hwpe_pkg::E_IDLE;
      end
      // Clearing go or leaving sequence modes aborts; this is how endless repeats end
      if (s.eng != hwpe_pkg::E_IDLE && (!s.go || !seqMode))
         d.eng = hwpe_pkg::E_IDLE;

      if (modeSel == hwpe_pkg::MODE_EDGE && pinRise)
         d.go = 1'b1;
      else if (modeSel == hwpe_pkg::MODE_LEVEL && s.pinSync[1] == s.pinSync[2])
         d.go = s.pinSync[2];

      // Register access from the link side; a software write wins over self-clear
      d.reqSync = {s.reqSync[1:0], l.reqTgl};
      acc       = (s.reqSync[1] == s.reqSync[2]) && (s.reqSync[2] != s.ackTgl);
      if (acc)
      begin
         d.ackTgl = s.reqSync[2];
         case (accAddr)
            hwpe_pkg::ADDR_MODE:      d.rdData = s.modeReg;
            hwpe_pkg::ADDR_RTAMP:     d.rdData = s.rtAmp;
            hwpe_pkg::ADDR_GO:        d.rdData = {7'h00, s.go};
            hwpe_pkg::ADDR_LOOPCFG:   d.rdData = s.loopCfg;
            hwpe_pkg::ADDR_INCTRL:    d.rdData = s.inCtrl;
            hwpe_pkg::ADDR_RAM_HI:    d.rdData = {5'h00, s.ramPtr[10:8]};
            hwpe_pkg::ADDR_RAM_LO:    d.rdData = s.ramPtr[7:0];
            hwpe_pkg::ADDR_RAM_DATA:  d.rdData = ramHostData;
            default:
               if (accAddr >= hwpe_pkg::ADDR_SEQ_FIRST && accAddr <= hwpe_pkg::ADDR_SEQ_LAST)
                  d.rdData = s.seq[3'(accAddr - hwpe_pkg::ADDR_SEQ_FIRST)];
               else
                  d.rdData = 8'h00;
         endcase
         if (accAddr == hwpe_pkg::ADDR_RAM_DATA)
            d.ramPtr = s.ramPtr + 11'h001;
         if (l.held.we)
         begin
            case (accAddr)
               hwpe_pkg::ADDR_MODE:     d.modeReg = l.held.wdata;
               hwpe_pkg::ADDR_RTAMP:    d.rtAmp   = l.held.wdata;
               hwpe_pkg::ADDR_GO:       d.go      = l.held.wdata[0];
               hwpe_pkg::ADDR_LOOPCFG:  d.loopCfg = l.held.wdata;
               hwpe_pkg::ADDR_INCTRL:   d.inCtrl  = l.held.wdata;
               hwpe_pkg::ADDR_RAM_HI:   d.ramPtr[10:8] = l.held.wdata[2:0];
               hwpe_pkg::ADDR_RAM_LO:   d.ramPtr[7:0]  = l.held.wdata;
               hwpe_pkg::ADDR_RAM_DATA: ramWe = 1'b1;
               default:
                  if (accAddr >= hwpe_pkg::ADDR_SEQ_FIRST && accAddr <= hwpe_pkg::ADDR_SEQ_LAST)
                     d.seq[3'(accAddr - hwpe_pkg::ADDR_SEQ_FIRST)] = l.held.wdata;
            endcase
         end
      end

      // Drive selection
      if (s.modeReg[hwpe_pkg::BIT_STANDBY])
      begin
         lvl = 8'h00;
         act = 1'b0;
      end
      else if (modeSel == hwpe_pkg::MODE_REALTIME)
      begin
         lvl = s.inCtrl[hwpe_pkg::BIT_RT_FORMAT] ? s.rtAmp
                                                 : (s.rtAmp ^ hwpe_pkg::MID_SCALE);
         act = 1'b1;
      end
      else if (modeSel == hwpe_pkg::MODE_INPUT)
      begin
         lvl = s.inCtrl[hwpe_pkg::BIT_ANALOG_SEL] ? analogLevel : s.pwmDuty;
         act = 1'b1;
      end
      else if (seqMode && s.eng == hwpe_pkg::E_HOLD)
      begin
         lvl = s.ramp
             ? rampLevel(voltToLevel(s.v1, s.loopCfg[hwpe_pkg::BIT_SIGNED_SEL]),
                         voltToLevel(s.v2, s.loopCfg[hwpe_pkg::BIT_SIGNED_SEL]),
                         s.elapsed, s.ticks)
             : voltToLevel(s.v1, s.loopCfg[hwpe_pkg::BIT_SIGNED_SEL]);
         act = 1'b1;
      end
      else if (!seqMode || s.eng == hwpe_pkg::E_IDLE || s.eng == hwpe_pkg::E_PAUSE)
      begin
         lvl = 8'h00;
         act = 1'b0;
      end
      if (act && s.loopCfg[hwpe_pkg::BIT_SIGNED_SEL] && !s.inCtrl[hwpe_pkg::BIT_OPEN_LOOP]
          && lvl < hwpe_pkg::MID_SCALE)
         lvl = hwpe_pkg::MID_SCALE;
      d.drive  = lvl;
      d.active = act;
   end

   always_ff @(posedge clk_sys)
   begin
      if (sys_rst)
         s <= SYS_RESET;
      else if (clkEn)
         s <= d;
   end

   // Link side: request held stable until the toggle comes back
   always_comb
   begin
      ld         = l;
      ld.done    = 1'b0;
      ld.ackSync = {l.ackSync[1:0], s.ackTgl};
      if (!l.ready && l.ackSync[1] == l.ackSync[2] && l.ackSync[2] == l.reqTgl)
      begin
         ld.ready = 1'b1;
         ld.rdata = s.rdData;
         ld.done  = 1'b1;
      end
      else if (l.ready && linkReq)
      begin
         ld.held   = '{we: linkWe, addr: linkAddr, wdata: linkWdata};
         ld.reqTgl = ~l.reqTgl;
         ld.ready  = 1'b0;
      end
   end

   always_ff @(posedge linkClk)
   begin
      if (linkRst)
         l <= LINK_RESET;
      else
         l <= ld;
   end

   assign linkReady   = l.ready;
   assign linkRdata   = l.rdata;
   assign linkDone    = l.done;
   assign driveLevel  = s.drive;
   assign driveActive = s.active;
endmodule // hwpe_playback_engine

// ===== testbench/hwpe_host_model.sv
`timescale 1ns/1ns
module hwpe_host_model (
   input  wire logic       linkClk,
   output logic            linkReq,
   output logic            linkWe,
   output logic [7:0]      linkAddr,
   output logic [7:0]      linkWdata,
   input  wire logic       linkReady,
   input  wire logic [7:0] linkRdata,
   input  wire logic       linkDone
);
   initial
   begin
      linkReq = 1'b0;
      linkWe = 1'b0;
      linkAddr = 8'h00;
      linkWdata = 8'h00;
   end

   // Idle cycles model a slow host; released lines carry inverted values
   task automatic access(input logic we, input logic [7:0] a, input logic [7:0] d,
                         input int idle, output logic [7:0] rd);
      repeat (idle + 1) @(negedge linkClk);
      linkReq = 1'b1;
      linkWe = we;
      linkAddr = a;
      linkWdata = d;
      // No local limit: a hang runs into the bench watchdog
      do
         @(posedge linkClk);
      while (linkReady !== 1'b1);
      @(negedge linkClk);
      linkReq = 1'b0;
      linkWe = ~we;
      linkAddr = ~a;
      linkWdata = ~d;
      do
         @(posedge linkClk);
      while (linkDone !== 1'b1);
      rd = linkRdata;
   endtask
endmodule // hwpe_host_model

// ===== testbench/hwpe_monitor.sv
`timescale 1ns/1ns
module hwpe_monitor (
   input wire logic       clk_sys,
   input wire logic       sys_rst,
   input wire logic       clkEn,
   input wire logic       linkClk,
   input wire logic       linkRst,
   input wire logic       linkReq,
   input wire logic       linkReady,
   input wire logic [7:0] linkRdata,
   input wire logic       linkDone,
   input wire logic [7:0] driveLevel,
   input wire logic       driveActive
);
   property p_sys_reset;
      @(posedge clk_sys) sys_rst |=> !driveActive && driveLevel == 8'h00;
   endproperty
   a_sys_reset: assert property (p_sys_reset)
      else $error("Drive not idle after reset");
   property p_idle_zero;
      @(posedge clk_sys) disable iff (sys_rst) !driveActive |-> driveLevel == 8'h00;
   endproperty
   a_idle_zero: assert property (p_idle_zero)
      else $error("Drive level not zero while idle");
   property p_freeze;
      @(posedge clk_sys) disable iff (sys_rst)
         !clkEn |=> $stable(driveLevel) && $stable(driveActive);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("Drive moved while clock enable low");
   property p_take;
      @(posedge linkClk) disable iff (linkRst) linkReq && linkReady |=> !linkReady;
   endproperty
   a_take: assert property (p_take)
      else $error("Request not taken");
   // Busy lasts at least the crossing there and back
   property p_busy_min;
      @(posedge linkClk) disable iff (linkRst) $fell(linkReady) |-> !linkReady [*4];
   endproperty
   a_busy_min: assert property (p_busy_min)
      else $error("Access answered too early");
   property p_answer;
      @(posedge linkClk) disable iff (linkRst) $fell(linkReady) |-> ##[4:60] linkDone;
   endproperty
   a_answer: assert property (p_answer)
      else $error("Access never completed");
   property p_done_ready;
      @(posedge linkClk) disable iff (linkRst)
         linkDone |-> linkReady && !$past(linkReady) ##1 !linkDone;
   endproperty
   a_done_ready: assert property (p_done_ready)
      else $error("Completion pulse malformed");
   property p_link_reset;
      @(posedge linkClk) linkRst |=> linkReady && !linkDone && linkRdata == 8'h00;
   endproperty
   a_link_reset: assert property (p_link_reset)
      else $error("Register port not idle after reset");
   c_drive: cover property (@(posedge clk_sys) driveActive && driveLevel == 8'h40);
   c_stop: cover property (@(posedge clk_sys) $fell(driveActive));
   c_done: cover property (@(posedge linkClk) linkDone);
endmodule // hwpe_monitor

bind hwpe_playback_engine hwpe_monitor i_mon (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .linkClk(linkClk),
   .linkRst(linkRst), .linkReq(linkReq), .linkReady(linkReady), .linkRdata(linkRdata),
   .linkDone(linkDone), .driveLevel(driveLevel), .driveActive(driveActive));

// ===== testbench/testbench.sv
`timescale 1ns/1ns
module testbench;
   localparam int TK = 20;
   localparam int PS = 40;
   logic       clk_sys = 1'b0;
   logic       linkClk = 1'b0;
   logic       sys_rst = 1'b1;
   logic       linkRst = 1'b1;
   logic       clkEn = 1'b1;
   logic       pin = 1'b0;
   logic [7:0] analogLevel = 8'h00;
   logic       linkReq;
   logic       linkWe;
   logic       linkReady;
   logic       linkDone;
   logic       driveActive;
   logic [7:0] linkAddr;
   logic [7:0] linkWdata;
   logic [7:0] linkRdata;
   logic [7:0] driveLevel;
   logic [7:0] rdv;
   int         mismatches = 0;
   int         num_checks = 0;

   always #20 clk_sys = ~clk_sys;
   initial #7 forever #15 linkClk = ~linkClk;

   hwpe_playback_engine #(.TICK_CYCLES(TK), .PAUSE_CYCLES(PS)) i_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst), .clkEn(clkEn), .linkClk(linkClk),
      .linkRst(linkRst), .linkReq(linkReq), .linkWe(linkWe), .linkAddr(linkAddr),
      .linkWdata(linkWdata), .linkReady(linkReady), .linkRdata(linkRdata),
      .linkDone(linkDone), .inputTriggerPin(pin), .analogLevel(analogLevel),
      .driveLevel(driveLevel), .driveActive(driveActive));
   hwpe_host_model i_host (
      .linkClk(linkClk), .linkReq(linkReq), .linkWe(linkWe), .linkAddr(linkAddr),
      .linkWdata(linkWdata), .linkReady(linkReady), .linkRdata(linkRdata),
      .linkDone(linkDone));

   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic waitc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host.access(1'b1, a, d, 0, rdv);
      @(negedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
      i_host.access(1'b0, a, 8'h00, 2, rdv);
      chk(nm, rdv, e);
   endtask
   // Sets the RAM pointer, then streams up to eight bytes
   task automatic ld(input logic [10:0] a, input logic [63:0] v, input int n);
      wr(8'hfd, {5'h00, a[10:8]});
      wr(8'hfe, a[7:0]);
      for (int i = 0; i < n; i++)
         wr(8'hff, v[63 - 8 * i -: 8]);
   endtask
   task automatic tally_and_finish();
      if (mismatches == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic t_regs();
      rd(8'h01, 8'h40, "mode");
      rd(8'h04, 8'h01, "slot1");
      rd(8'h0c, 8'h00, "go");
      rd(8'h1d, 8'h80, "inctrl");
      wr(8'h30, 8'h5a);
      rd(8'h30, 8'h00, "unmapped");
   endtask
   task automatic t_rtp();
      wr(8'h1d, 8'ha8);
      wr(8'h02, 8'h37);
      wr(8'h01, 8'h05);
      waitc(4);
      chk("rtActive", {7'h00, driveActive}, 8'h01);
      chk("rtLevel", driveLevel, 8'h37);
      wr(8'h02, 8'hc5);
      waitc(4);
      chk("rtFollow", driveLevel, 8'hc5);
      wr(8'h1d, 8'ha0);
      waitc(4);
      chk("rtSigned", driveLevel, 8'h45);
      wr(8'h1d, 8'h88);
      wr(8'h02, 8'h37);
      waitc(4);
      chk("clamp", driveLevel, 8'h80);
   endtask
   task automatic t_input();
      int c;
      wr(8'h1d, 8'ha2);
      analogLevel = 8'h9a;
      wr(8'h01, 8'h03);
      waitc(4);
      chk("analog", driveLevel, 8'h9a);
      clkEn = 1'b0;
      analogLevel = 8'hd0;
      waitc(8);
      chk("frozen", driveLevel, 8'h9a);
      clkEn = 1'b1;
      waitc(4);
      chk("anFollow", driveLevel, 8'hd0);
      wr(8'h1d, 8'ha0);
      // Quarter duty in two-cycle pulses, which survive the pin filter: 64 highs per window
      for (c = 0; c < 800; c++)
      begin
         pin = (c % 8 < 2);
         waitc(1);
      end
      pin = 1'b0;
      chk("pwm", driveLevel, 8'h40);
      wr(8'h01, 8'h43);
      waitc(4);
      chk("standby", {7'h00, driveActive}, 8'h00);
   endtask
   task automatic t_seq();
      int on, gap, pause, n40, n0f, e0a, e14;
      logic [7:0] prev;
      on = 0; gap = 0; pause = 0; n40 = 0; n0f = 0; e0a = 0; e14 = 0;
      prev = 8'h00;
      wr(8'h1c, 8'h75);
      ld(11'h000, 64'h0000102400200400, 7); // Revision and two entries
      ld(11'h010, 64'h85020a0100000000, 4); // Ramp into a hold
      ld(11'h020, 64'h2001000100000000, 4);
      ld(11'h010, 64'h0, 0);
      rd(8'hff, 8'h85, "ram0");
      rd(8'hff, 8'h02, "ram1");
      wr(8'h04, 8'h01); // Valid identifiers only
      wr(8'h05, 8'h81);
      wr(8'h06, 8'h02);
      wr(8'h07, 8'h00);
      wr(8'h01, 8'h00);
      wr(8'h0c, 8'h01);
      repeat (700)
      begin
         waitc(1);
         if (driveActive === 1'b1)
         begin
            pause += gap;
            on = 1;
            gap = 0;
            n40 += (driveLevel === 8'h40);
            n0f += (driveLevel === 8'h0f);
            e0a += (driveLevel === 8'h0a && prev !== 8'h0a);
            e14 += (driveLevel === 8'h14 && prev !== 8'h14);
         end
         else
            gap += on;
         prev = driveLevel;
      end
      chk("repeats", e0a[7:0], 8'h02);
      chk("rampMid", n0f[7:0], 8'h28);
      chk("rampEnd", e14[7:0], 8'h02);
      chk("effect2", n40[7:0], 8'h14);
      chk("pause", {7'h00, pause >= 40 && pause <= 50}, 8'h01);
      rd(8'h0c, 8'h00, "goClear");
   endtask
   task automatic t_trig();
      wr(8'h04, 8'h02);
      wr(8'h05, 8'h00);
      for (logic [7:0] m = 8'h01; m <= 8'h02; m++)
      begin
         wr(8'h01, m);
         waitc(20);
         chk("noStart", {7'h00, driveActive}, 8'h00);
         pin = 1'b1;
         waitc(20);
         chk("trigStart", {7'h00, driveActive}, 8'h01);
         pin = 1'b0;
         waitc(80);
      end
      wr(8'h01, 8'h40);
   endtask

   initial
   begin
      repeat (4) @(negedge clk_sys);
      sys_rst = 1'b0;
      @(negedge linkClk);
      linkRst = 1'b0;
      waitc(2);
      t_regs();
      t_rtp();
      t_input();
      t_seq();
      t_trig();
      tally_and_finish();
   end

   initial
   begin
      repeat (40000) @(posedge clk_sys);
      mismatches++;
      tally_and_finish();
   end
endmodule // testbench
